// ---- verilog/mbd_consts.svh ----
// Offsets, field positions, reset values and timing counts of the bias detect block.
// Assumes the includer compiles it once per unit; the guard stops double definition.
`ifndef MBD_CONSTS_SVH
`define MBD_CONSTS_SVH

// ==========================================================================
// Register indices (byte address is four times the index)
// ==========================================================================
`define MBD_IDX_BIAS_CTRL     12'h006
`define MBD_IDX_CLK_RATES2    12'h016
`define MBD_IDX_SEQ_DET_CLK   12'h06c
`define MBD_IDX_POLARITY      12'h080
`define MBD_IDX_IRQ_STATUS    12'h081
`define MBD_IDX_IRQ_MASK      12'h082
`define MBD_IDX_DET_STATE     12'h083

// ==========================================================================
// Field positions and reset values
// ==========================================================================
`define MBD_BIAS_EN_BIT       0
`define MBD_DET_EN_BIT        1
`define MBD_BTN_THR_LSB       2
`define MBD_INS_THR_LSB       4
`define MBD_SYS_CLK_BIT       2
`define MBD_DET_CLK_BIT       8
`define MBD_REG_RESET         16'h0000
`define MBD_ERR_DATA          16'h0000

// Threshold codes: 0.063, 0.26, 0.45, 0.635 mA insert; 0.52, 0.77, 1.2, 1.43 mA button.
`define MBD_THR_LOWEST        2'h0
`define MBD_THR_HIGHEST       2'h3

// ==========================================================================
// Timing
// ==========================================================================
`define MBD_CLK_PERIOD_NS     25
`define MBD_MEAS_PERIOD_NS    1000
`define MBD_MEAS_CYCLES       ((`MBD_MEAS_PERIOD_NS + `MBD_CLK_PERIOD_NS - 1) / `MBD_CLK_PERIOD_NS)
`define MBD_INS_RUN           4'h4
`define MBD_BTN_RUN           4'ha

`endif

// ---- verilog/mbd_pkg.sv ----
// Types shared by the bias current detect block.
// Assumes nothing beyond a SystemVerilog compiler.
package mbd_pkg;

   // ==========================================================================
   // Types
   // ==========================================================================
   typedef logic [15:0] mbd_word_t;
   typedef logic [11:0] mbd_addr_t;
   typedef logic [3:0]  mbd_count_t;
   typedef enum {MBD_DET_INSERT, MBD_DET_BUTTON} mbd_det_t;

endpackage

// ---- verilog/mbd_top.sv ----
// Bias current accessory and hook switch detection with an APB register slave.
// Assumes APB master on pclk, comparator levels already synchronous to pclk.
//
// The APB register port was chosen for this implementation.
`include "mbd_consts.svh"

module mbd_top
   import mbd_pkg::*;
#(
   parameter int unsigned MEAS_CYCLES = `MBD_MEAS_CYCLES,
   parameter mbd_count_t  INS_RUN     = `MBD_INS_RUN,
   parameter mbd_count_t  BTN_RUN     = `MBD_BTN_RUN
)
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        mclk_present,
   input  wire logic        insert_above_on,
   input  wire logic        insert_above_off,
   input  wire logic        button_above_on,
   input  wire logic        button_above_off,
   output logic             bias_out_enable,
   output logic             current_detect_enable,
   output logic      [1:0]  insert_threshold_sel,
   output logic      [1:0]  button_threshold_sel,
   output logic             gpio_insert_state,
   output logic             gpio_button_state,
   output logic             irq
);

   // ==========================================================================
   // Register storage and bus decode
   // ==========================================================================
   mbd_word_t  mic_bias_control;
   mbd_word_t  clock_rates_two;
   mbd_word_t  sequence_and_detect_clock_control;
   logic [1:0] polarity;
   logic [1:0] irq_status;
   logic [1:0] irq_mask;
   mbd_word_t  rd_data;
   logic       rd_err;
   logic       setup;
   logic       access;
   logic       wr;
   logic [1:0] clr;
   logic [1:0] set_flag;
   logic       clk_ok;
   logic [1:0] det_state;

   function automatic logic hit(input mbd_addr_t a, input mbd_addr_t idx);
      return a == {idx[9:0], 2'b00};
   endfunction

   assign setup  = psel & ~penable;
   assign access = psel & penable & pready;
   assign wr     = access & pwrite;

   always_comb
   begin
      rd_err  = 1'b0;
      rd_data = `MBD_ERR_DATA;
      if (hit(paddr, `MBD_IDX_BIAS_CTRL))
         rd_data = mic_bias_control;
      else if (hit(paddr, `MBD_IDX_CLK_RATES2))
         rd_data = clock_rates_two;
      else if (hit(paddr, `MBD_IDX_SEQ_DET_CLK))
         rd_data = sequence_and_detect_clock_control;
      else if (hit(paddr, `MBD_IDX_POLARITY))
         rd_data = {14'h0, polarity};
      else if (hit(paddr, `MBD_IDX_IRQ_STATUS))
         rd_data = {14'h0, irq_status};
      else if (hit(paddr, `MBD_IDX_IRQ_MASK))
         rd_data = {14'h0, irq_mask};
      else if (hit(paddr, `MBD_IDX_DET_STATE))
         rd_data = {13'h0, clk_ok, det_state};
      else
         rd_err = 1'b1;
   end

   // The answer is registered in the setup cycle, so every access has exactly one wait-free
   // access phase and the bus outputs come straight from flip-flops.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
         prdata  <= 32'h0;
      end
      else
      begin
         pready  <= setup;
         pslverr <= setup & rd_err;
         if (setup)
            prdata <= {16'h0, rd_data};
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         mic_bias_control                  <= `MBD_REG_RESET;
         clock_rates_two                   <= `MBD_REG_RESET;
         sequence_and_detect_clock_control <= `MBD_REG_RESET;
         polarity                          <= 2'h0;
         irq_mask                          <= 2'h0;
      end
      else if (wr)
      begin
         if (hit(paddr, `MBD_IDX_BIAS_CTRL))
            mic_bias_control <= {10'h0, pwdata[5:0]};
         if (hit(paddr, `MBD_IDX_CLK_RATES2))
            clock_rates_two <= pwdata[15:0];
         if (hit(paddr, `MBD_IDX_SEQ_DET_CLK))
            sequence_and_detect_clock_control <= pwdata[15:0];
         if (hit(paddr, `MBD_IDX_POLARITY))
            polarity <= pwdata[1:0];
         if (hit(paddr, `MBD_IDX_IRQ_MASK))
            irq_mask <= pwdata[1:0];
      end
   end

   // ==========================================================================
   // Analogue control outputs
   // ==========================================================================
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         bias_out_enable       <= 1'b0;
         current_detect_enable <= 1'b0;
         insert_threshold_sel  <= `MBD_THR_LOWEST;
         button_threshold_sel  <= `MBD_THR_LOWEST;
      end
      else
      begin
         bias_out_enable       <= mic_bias_control[`MBD_BIAS_EN_BIT];
         current_detect_enable <= mic_bias_control[`MBD_DET_EN_BIT];
         insert_threshold_sel  <= mic_bias_control[`MBD_INS_THR_LSB +: 2];
         button_threshold_sel  <= mic_bias_control[`MBD_BTN_THR_LSB +: 2];
      end
   end

   // ==========================================================================
   // Measurement tick and clock qualification
   // ==========================================================================
   logic [15:0] div_cnt;
   logic        meas_tick;

   assign clk_ok = mclk_present & clock_rates_two[`MBD_SYS_CLK_BIT]
                 & sequence_and_detect_clock_control[`MBD_DET_CLK_BIT];

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         div_cnt   <= 16'h0;
         meas_tick <= 1'b0;
      end
      else
      begin
         meas_tick <= (div_cnt == 16'(MEAS_CYCLES - 1));
         if (div_cnt == 16'(MEAS_CYCLES - 1))
            div_cnt <= 16'h0;
         else
            div_cnt <= div_cnt + 16'h1;
      end
   end

   // ==========================================================================
   // Detectors: index 0 is insertion, index 1 is the button
   // ==========================================================================
   logic [1:0] above_on;
   logic [1:0] above_off;
   logic [1:0] hyst;
   logic [1:0] seen_up;
   logic [1:0] seen_dn;
   logic [1:0] ev_up;
   logic [1:0] ev_dn;
   mbd_count_t cnt [2];
   mbd_count_t run_len [2];

   assign above_on  = {button_above_on, insert_above_on};
   assign above_off = {button_above_off, insert_above_off};
   assign run_len[MBD_DET_INSERT] = INS_RUN;
   assign run_len[MBD_DET_BUTTON] = BTN_RUN;

   // The upper comparator sets the level, only the lower one clears it, so a current
   // hovering between the two levels cannot chatter the detector.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         hyst <= 2'h0;
      else if (mic_bias_control[`MBD_DET_EN_BIT])
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (above_on[i])
               hyst[i] <= 1'b1;
            else if (!above_off[i])
               hyst[i] <= 1'b0;
         end
      end
   end

   // While clocking is unmet the filter is frozen, but one rise and one fall of level are each remembered,
   // so a short insertion or press with the clock stopped still yields its events later.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         det_state <= 2'h0;
         seen_up   <= 2'h0;
         seen_dn   <= 2'h0;
         ev_up     <= 2'h0;
         ev_dn     <= 2'h0;
         cnt[0]    <= 4'h0;
         cnt[1]    <= 4'h0;
      end
      else
      begin
         ev_up <= 2'h0;
         ev_dn <= 2'h0;
         for (int i = 0; i < 2; i++)
         begin
            if (!clk_ok)
            begin
               if ((hyst[i] & ~det_state[i]) | (seen_dn[i] & hyst[i]))
                  seen_up[i] <= 1'b1;
               if ((~hyst[i] & det_state[i]) | (seen_up[i] & ~hyst[i]))
                  seen_dn[i] <= 1'b1;
            end
            else if (meas_tick)
            begin
               if (seen_up[i] | seen_dn[i])
               begin
                  ev_up[i]     <= seen_up[i];
                  ev_dn[i]     <= seen_dn[i];
                  det_state[i] <= hyst[i];
                  seen_up[i]   <= 1'b0;
                  seen_dn[i]   <= 1'b0;
                  cnt[i]       <= 4'h0;
               end
               else if (hyst[i] != det_state[i])
               begin
                  if (cnt[i] + 4'h1 == run_len[i])
                  begin
                     det_state[i] <= hyst[i];
                     ev_up[i]     <= hyst[i];
                     ev_dn[i]     <= ~hyst[i];
                     cnt[i]       <= 4'h0;
                  end
                  else
                     cnt[i] <= cnt[i] + 4'h1;
               end
               else
                  cnt[i] <= 4'h0;
            end
         end
      end
   end

   // ==========================================================================
   // Event flags, mask and pin outputs
   // ==========================================================================
   always_comb
   begin
      clr = 2'h0;
      if (wr && hit(paddr, `MBD_IDX_IRQ_STATUS))
         clr = pwdata[1:0];
      for (int i = 0; i < 2; i++)
         set_flag[i] = polarity[i] ? ev_dn[i] : ev_up[i];
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         irq_status        <= 2'h0;
         irq               <= 1'b0;
         gpio_insert_state <= 1'b0;
         gpio_button_state <= 1'b0;
      end
      else
      begin
         // A set arriving with its clear wins, so no event is dropped.
         irq_status        <= (irq_status & ~clr) | set_flag;
         irq               <= |(irq_status & irq_mask);
         gpio_insert_state <= det_state[MBD_DET_INSERT];
         gpio_button_state <= det_state[MBD_DET_BUTTON];
      end
   end

   // ==========================================================================
   // Assertions
   // ==========================================================================
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   logic wr_ctrl;
   assign wr_ctrl = wr & hit(paddr, `MBD_IDX_BIAS_CTRL);

   property p_bias_follows_write;
      wr_ctrl |=> ##1 bias_out_enable == $past(pwdata[0], 2);
   endproperty
   a_bias_follows_write: assert property (p_bias_follows_write)
      else $error("bias enable does not follow control write");

   property p_no_event_when_off;
      !mic_bias_control[`MBD_DET_EN_BIT] && !current_detect_enable && hyst == 2'h0
         && det_state == 2'h0 && seen_up == 2'h0 |=> ev_up == 2'h0;
   endproperty
   a_no_event_when_off: assert property (p_no_event_when_off)
      else $error("event raised with detection disabled");

   property p_thresholds;
      wr_ctrl |=> ##1 insert_threshold_sel == $past(pwdata[5:4], 2)
                   && button_threshold_sel == $past(pwdata[3:2], 2);
   endproperty
   a_thresholds: assert property (p_thresholds)
      else $error("threshold select does not follow control write");

   property p_button_run;
      clk_ok && meas_tick && !seen_up[1] && !seen_dn[1] && hyst[1] != det_state[1]
         && cnt[1] != BTN_RUN - 4'h1 |=> $stable(det_state[1]);
   endproperty
   a_button_run: assert property (p_button_run)
      else $error("button state changed before the full run");

   property p_insert_flag;
      ev_up[0] && !polarity[0] |=> irq_status[0];
   endproperty
   a_insert_flag: assert property (p_insert_flag)
      else $error("insert flag not set on insertion");

   property p_button_flag;
      ev_dn[1] && polarity[1] |=> irq_status[1];
   endproperty
   a_button_flag: assert property (p_button_flag)
      else $error("button flag not set on release");

   property p_sticky;
      irq_status[0] && !clr[0] |=> irq_status[0];
   endproperty
   a_sticky: assert property (p_sticky)
      else $error("insert flag cleared on its own");

   property p_frozen;
      !clk_ok |=> $stable(det_state) && ev_up == 2'h0 && ev_dn == 2'h0;
   endproperty
   a_frozen: assert property (p_frozen)
      else $error("filter moved while clocking unmet");

   property p_resume;
      clk_ok && meas_tick && seen_up[0] |=> ev_up[0];
   endproperty
   a_resume: assert property (p_resume)
      else $error("change seen while stopped was not reported");

   property p_pin_delay;
      ev_up[0] |=> gpio_insert_state && irq_status[0] == !polarity[0] | $past(irq_status[0]);
   endproperty
   a_pin_delay: assert property (p_pin_delay)
      else $error("pin state and flag disagree in timing");

   property p_irq;
      (irq_status & irq_mask) != 2'h0 |=> irq;
   endproperty
   a_irq: assert property (p_irq)
      else $error("unmasked flag did not raise interrupt");

   c_insert: cover property (ev_up[0] ##1 irq_status[0]);
   c_button: cover property (ev_up[1] ##1 irq_status[1]);
   c_resume: cover property (!clk_ok ##1 clk_ok [*1] ##[1:100] ev_up[0]);
   c_irq:    cover property (irq ##[1:20] !irq);

endmodule

// ---- bench/mbd_mic_model.sv ----
// Behavioural electret microphone and hook switch, seen as the two bias current comparators.
// Assumes the bench sets the load current in microamps and the block supplies threshold codes.
module mbd_mic_model
(
   input  wire logic [0:0]  bias_out_enable,
   input  wire logic [1:0]  insert_threshold_sel,
   input  wire logic [1:0]  button_threshold_sel,
   input  wire logic [15:0] load_ua,
   output logic             insert_above_on,
   output logic             insert_above_off,
   output logic             button_above_on,
   output logic             button_above_off
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // Comparator levels
   // ==========================================================================
   // The release level sits a fifth below the trip level, so noise near one level cannot chatter.
   int ins_lvl [4] = '{63, 260, 450, 635};
   int btn_lvl [4] = '{520, 770, 1200, 1430};
   int cur;

   always_comb
   begin
      cur = bias_out_enable ? int'(load_ua) : 0;
      insert_above_on  = cur > ins_lvl[insert_threshold_sel];
      insert_above_off = cur > ins_lvl[insert_threshold_sel] * 4 / 5;
      button_above_on  = cur > btn_lvl[button_threshold_sel];
      button_above_off = cur > btn_lvl[button_threshold_sel] * 4 / 5;
   end
endmodule

// ---- bench/mic_bias_current_detect_bench.sv ----
// Self-checking bench for the bias current detect block with a microphone model.
// Assumes the design header is on the include path; the measure tick is shortened to 2 cycles.
`include "mbd_consts.svh"
module mic_bias_current_detect_bench
   import mbd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================================
   // Constants and signals
   // ==========================================================================
   localparam int        MEAS   = 2;
   localparam int        T_INS  = MEAS * `MBD_INS_RUN + 8;
   localparam int        T_BTN  = MEAS * `MBD_BTN_RUN + 8;
   localparam mbd_addr_t A_CTRL = `MBD_IDX_BIAS_CTRL << 2;
   localparam mbd_addr_t A_CLK  = `MBD_IDX_CLK_RATES2 << 2;
   localparam mbd_addr_t A_SEQ  = `MBD_IDX_SEQ_DET_CLK << 2;
   localparam mbd_addr_t A_POL  = `MBD_IDX_POLARITY << 2;
   localparam mbd_addr_t A_STS  = `MBD_IDX_IRQ_STATUS << 2;
   localparam mbd_addr_t A_MSK  = `MBD_IDX_IRQ_MASK << 2;
   localparam mbd_addr_t A_STA  = `MBD_IDX_DET_STATE << 2;
   logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, mclk_present, err;
   logic        ins_on, ins_off, btn_on, btn_off, bias_en, det_en, gpio_ins, gpio_btn, irq;
   logic [1:0]  ins_sel, btn_sel;
   logic [11:0] paddr;
   logic [15:0] load_ua;
   logic [31:0] pwdata, prdata, rd;
   int          bad_count, n_checks;

   mbd_top #(.MEAS_CYCLES(MEAS)) u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .mclk_present(mclk_present),
      .insert_above_on(ins_on), .insert_above_off(ins_off), .button_above_on(btn_on),
      .button_above_off(btn_off), .bias_out_enable(bias_en), .current_detect_enable(det_en),
      .insert_threshold_sel(ins_sel), .button_threshold_sel(btn_sel),
      .gpio_insert_state(gpio_ins), .gpio_button_state(gpio_btn), .irq(irq));

   mbd_mic_model u_mic (.bias_out_enable(bias_en), .insert_threshold_sel(ins_sel),
      .button_threshold_sel(btn_sel), .load_ua(load_ua), .insert_above_on(ins_on),
      .insert_above_off(ins_off), .button_above_on(btn_on), .button_above_off(btn_off));

   initial
   begin
      pclk = 1'b0;
      forever #12.5 pclk = ~pclk;
   end

   // ==========================================================================
   // Shared tasks
   // ==========================================================================
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      n_checks++;
      if (seen !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Holds the request until pready is seen, then releases and idles one cycle.
   task automatic apb(input logic wr, input mbd_addr_t a, input logic [31:0] d);
      int k;
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      k = 0;
      do
      begin
         @(posedge pclk);
         k++;
      end
      while (pready !== 1'b1 && k < 50);
      chk(pready, 1'b1, "pready");
      rd = prdata;
      err = pslverr;
      psel    <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask

   task automatic wr(input mbd_addr_t a, input logic [31:0] d);
      apb(1'b1, a, d);
   endtask

   task automatic rdchk(input mbd_addr_t a, input logic [31:0] exp, input string what);
      apb(1'b0, a, 32'h0);
      chk(rd, exp, what);
   endtask

   task automatic wait_c(input int n);
      repeat (n) @(posedge pclk);
   endtask

   task automatic clocking_ok(input int k, input logic on);
      if (k == 0)
         mclk_present <= on;
      else if (k == 1)
         wr(A_CLK, on ? 32'h4 : 32'h0);
      else
         wr(A_SEQ, on ? 32'h100 : 32'h0);
   endtask

   // ==========================================================================
   // Scenarios
   // ==========================================================================
   task automatic t_reset();
      mbd_addr_t regs [7] = '{A_CTRL, A_CLK, A_SEQ, A_POL, A_STS, A_MSK, A_STA};
      chk({bias_en, det_en, ins_sel, btn_sel, gpio_ins, gpio_btn, irq}, 0, "reset out");
      foreach (regs[i]) rdchk(regs[i], 0, "reset value");
      apb(1'b0, 12'h300, 32'h0);
      chk(err, 1'b1, "unmapped error");
      chk(rd, 32'h0, "unmapped read");
      $display("test reset done");
   endtask

   task automatic t_ctrl();
      int v;
      for (int c = 0; c < 4; c++)
      begin
         v = c * 16 + (3 - c) * 4 + c;
         wr(A_CTRL, 32'hffc0 | v);
         wait_c(2);
         chk({ins_sel, btn_sel, det_en, bias_en}, v, "control outputs");
         rdchk(A_CTRL, v, "control readback");
      end
      $display("test control done");
   endtask

   task automatic t_insert();
      wr(A_CLK, 32'h4);
      wr(A_SEQ, 32'h100);
      wr(A_CTRL, 32'h3);
      wr(A_MSK, 32'h0);
      load_ua <= 16'd300;
      wait_c(T_INS);
      chk(gpio_ins, 1'b1, "insert state");
      rdchk(A_STS, 1, "insert flag");
      chk(irq, 1'b0, "masked irq");
      wait_c(T_INS);
      rdchk(A_STS, 1, "flag sticky");
      wr(A_MSK, 32'h1);
      wait_c(3);
      chk(irq, 1'b1, "irq raised");
      wr(A_STS, 32'h1);
      wait_c(3);
      chk(irq, 1'b0, "irq cleared");
      rdchk(A_STS, 0, "flag cleared");
      // Socket bounce is waited out before the polarity is changed.
      wait_c(20);
      wr(A_POL, 32'h1);
      load_ua <= 16'd0;
      wait_c(T_INS);
      chk(gpio_ins, 1'b0, "removed state");
      rdchk(A_STS, 1, "removal flag");
      wr(A_STS, 32'h1);
      load_ua <= 16'd300;
      wait_c(T_INS);
      rdchk(A_STS, 0, "no insert flag inverted");
      wait_c(20);
      wr(A_POL, 32'h0);
      $display("test insert done");
   endtask

   task automatic t_button();
      wr(A_MSK, 32'h3);
      load_ua <= 16'd1000;
      wait_c(MEAS * 6);
      load_ua <= 16'd300;
      wait_c(T_BTN);
      chk(gpio_btn, 1'b0, "short run");
      rdchk(A_STS, 0, "short run flag");
      load_ua <= 16'd1000;
      wait_c(T_BTN);
      chk(gpio_btn, 1'b1, "press state");
      rdchk(A_STS, 2, "press flag");
      load_ua <= 16'd450;
      wait_c(T_BTN);
      chk(gpio_btn, 1'b1, "hysteresis hold");
      load_ua <= 16'd300;
      wait_c(T_BTN);
      chk(gpio_btn, 1'b0, "release state");
      wr(A_STS, 32'h3);
      wr(A_POL, 32'h2);
      load_ua <= 16'd1000;
      wait_c(T_BTN);
      rdchk(A_STS, 0, "press inverted");
      load_ua <= 16'd300;
      wait_c(T_BTN);
      rdchk(A_STS, 2, "release flag");
      wr(A_STS, 32'h3);
      wr(A_POL, 32'h0);
      $display("test button done");
   endtask

   task automatic t_clock();
      for (int k = 0; k < 3; k++)
      begin
         load_ua <= 16'd0;
         wait_c(T_INS);
         wr(A_STS, 32'h3);
         clocking_ok(k, 1'b0);
         load_ua <= 16'd300;
         wait_c(T_BTN);
         chk(gpio_ins, 1'b0, "held while stopped");
         rdchk(A_STS, 0, "no flag while stopped");
         rdchk(A_STA, 0, "state while stopped");
         clocking_ok(k, 1'b1);
         wait_c(T_INS);
         chk(gpio_ins, 1'b1, "late state");
         rdchk(A_STS, 1, "late flag");
         rdchk(A_STA, 5, "state register");
      end
      $display("test clocking done");
   endtask

   // ==========================================================================
   // Sequence, watchdog and verdict
   // ==========================================================================
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      load_ua = 16'd0;
      mclk_present = 1'b1;
      bad_count = 0;
      n_checks = 0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_ctrl();
      t_insert();
      t_button();
      t_clock();
      report_and_stop();
   end

   // The whole run needs under a thousand cycles; twenty thousand means a hang.
   initial
   begin
      #500000;
      bad_count++;
      report_and_stop();
   end
endmodule
